// ==== bvcg_defs.svh ====
`ifndef BVCG_DEFS_SVH
`define BVCG_DEFS_SVH

// register offsets (word index on the plain port)
`define BVCG_ADDR_W          4
`define BVCG_OFF_UV_LEVEL    4'h0
`define BVCG_OFF_OV_LEVEL    4'h1
`define BVCG_OFF_OV_METHOD   4'h2
`define BVCG_OFF_ACC_LEVEL   4'h3
`define BVCG_OFF_RUN_LEVEL   4'h4
`define BVCG_OFF_RAMP_SEL    4'h5
`define BVCG_OFF_CONTROL     4'h6
`define BVCG_OFF_STATUS      4'h7
`define BVCG_OFF_FAULT       4'h8
`define BVCG_OFF_VOLT_MON    4'h9
`define BVCG_OFF_CURR_MON    4'ha

// control register fields
`define BVCG_CTL_HIGH_CLASS  0
`define BVCG_CTL_AUTO_RST    1
`define BVCG_CTL_FLT_RESET   2

// volts in 0.1 V steps, current in percent of rated
`define BVCG_UV_MIN_LO       16'd1500
`define BVCG_UV_MAX_LO       16'd2200
`define BVCG_UV_DEF_LO       16'd1800
`define BVCG_UV_MIN_HI       16'd3000
`define BVCG_UV_MAX_HI       16'd4400
`define BVCG_UV_DEF_HI       16'd3600
`define BVCG_OV_MAX_LO       16'd4500
`define BVCG_OV_MAX_HI       16'd9000
`define BVCG_OV_DEF_LO       16'd3800
`define BVCG_OV_DEF_HI       16'd7600
`define BVCG_HYST_LO         16'd300
`define BVCG_HYST_HI         16'd600
`define BVCG_CUR_MAX         8'd200
`define BVCG_CUR_DEF         8'd180
`define BVCG_RAMP_SEL_MAX    3'd5

// fault codes
`define BVCG_FC_NONE         8'h00
`define BVCG_FC_UV_ACCEL     8'h0b
`define BVCG_FC_UV_DECEL     8'h0c
`define BVCG_FC_UV_CONST     8'h0d

// sampling period: time and derived cycle count
`define BVCG_CLK_HZ          10000000
`define BVCG_SAMPLE_US       100
`define BVCG_SAMPLE_CYC      ((`BVCG_SAMPLE_US * (`BVCG_CLK_HZ / 1000000)))

`endif

// ==== bvcg_pkg.sv ====
package bvcg_pkg;

    typedef enum logic [2:0] {
        BVCG_RAMP_IDLE  = 3'b001,
        BVCG_RAMP_ACCEL = 3'b010,
        BVCG_RAMP_DECEL = 3'b100
    } bvcg_ramp_type;

    typedef enum logic [3:0] {
        BVCG_ST_STOP    = 4'b0001,
        BVCG_ST_RUN     = 4'b0010,
        BVCG_ST_FAULT   = 4'b0100,
        BVCG_ST_STOP_UV = 4'b1000
    } bvcg_state_type;

    typedef enum logic [1:0] {
        BVCG_ACT_NONE = 2'b00,
        BVCG_ACT_HOLD = 2'b01,
        BVCG_ACT_DOWN = 2'b10,
        BVCG_ACT_REG  = 2'b11
    } bvcg_act_type;

endpackage

// ==== bvcg_tick.sv ====
`timescale 1ns/1ps
`include "bvcg_defs.svh"

// sampling strobe: one pulse per control period
module bvcg_tick
    import bvcg_pkg::*;
(
    // clock and reset
    input  wire logic CLK_IN,
    input  wire logic ARST_N_IN,
    // strobe
    output logic      tick_out
);

    localparam logic [15:0] LAST = 16'(`BVCG_SAMPLE_CYC - 1);

    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic        wrap;

    assign wrap     = (cnt_reg == LAST);
    assign cnt_next = wrap ? 16'h0000 : cnt_reg + 16'h0001;
    assign tick_out = wrap;

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            cnt_reg <= 16'h0000;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

endmodule // bvcg_tick

// ==== bvcg_sync.sv ====
`timescale 1ns/1ps

// two-flop synchroniser, one per bit
module bvcg_sync
    import bvcg_pkg::*;
#(
    parameter int WIDTH = 6
) (
    // clock and reset
    input  wire logic             CLK_IN,
    input  wire logic             ARST_N_IN,
    // levels
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_reg;
            logic sync_reg;
            always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
                if (!ARST_N_IN) begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                end else begin
                    meta_reg <= d_in[i];
                    sync_reg <= meta_reg;
                end
            end
            assign q_out[i] = sync_reg;
        end
    endgenerate

endmodule // bvcg_sync

// ==== bvcg_guard.sv ====
`timescale 1ns/1ps
`include "bvcg_defs.svh"

// Summary of operation
// [R1] settable undervoltage level, range per class
// [R2] bus below level: outputs off, coast
// [R3] running undervoltage split accel/decel/constant
// [R4] running fault latches; auto restart optional
// [R5] stopped undervoltage flagged, not logged
// [R6] stopped flag clears at level plus margin
// [R7] overvoltage threshold range and defaults per class
// [R8] zero overvoltage threshold disables stall
// [R9] method select: traditional or smart
// [R10] traditional: hold frequency while decelerating high
// [R11] smart: regulate deceleration to hold bus
// [R12] host zeroes threshold with braking resistor
// [R13] acceleration current level 0 to 200 percent
// [R14] current stall only in V/f mode
// [R15] accel over level: hold frequency
// [R16] running current level 0 to 200 percent
// [R17] constant speed over level: ramp down
// [R18] ramp select 0 to 5
// [R19] fault codes 11, 12, 13
// [R20] compare each period, act next period
// [R21] new settings apply next period, faults kept
module bvcg_guard
    import bvcg_pkg::*;
(
    // clock and reset
    input  wire logic                    CLK_IN,
    input  wire logic                    ARST_N_IN,
    // register port
    input  wire logic [`BVCG_ADDR_W-1:0] REG_ADDR_IN,
    input  wire logic [15:0]             REG_WDATA_IN,
    input  wire logic                    REG_WR_IN,
    input  wire logic                    REG_RD_IN,
    output logic      [15:0]             REG_RDATA_OUT,
    // measurements, same clock domain
    input  wire logic [15:0]             BUS_VOLT_IN,
    input  wire logic [7:0]              OUT_CURR_IN,
    // ramp generator status pins
    input  wire logic                    RUN_CMD_IN,
    input  wire logic                    RAMP_ACCEL_IN,
    input  wire logic                    RAMP_DECEL_IN,
    input  wire logic                    VF_MODE_IN,
    input  wire logic                    AT_TARGET_IN,
    // actions toward ramp and inverter
    output logic                         DRIVE_EN_OUT,
    output logic                         RAMP_HOLD_OUT,
    output logic                         RAMP_DOWN_OUT,
    output logic                         DECEL_REG_OUT,
    output logic      [2:0]              STALL_RAMP_SEL_OUT,
    output logic                         UNDERVOLT_STOPPED_OUT,
    output logic                         FAULT_OUT,
    output logic      [7:0]              FAULT_CODE_OUT,
    output logic                         FAULT_LOG_OUT
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisation and sampling strobe

    logic [4:0] pins_sync;
    logic       tick;

    bvcg_sync #(
        .WIDTH (5)
    ) u_sync (
        .CLK_IN    (CLK_IN),
        .ARST_N_IN (ARST_N_IN),
        .d_in      ({RUN_CMD_IN, RAMP_ACCEL_IN, RAMP_DECEL_IN, VF_MODE_IN, AT_TARGET_IN}),
        .q_out     (pins_sync)
    );

    bvcg_tick u_tick (
        .CLK_IN    (CLK_IN),
        .ARST_N_IN (ARST_N_IN),
        .tick_out  (tick)
    );

    logic run_s;
    logic accel_s;
    logic decel_s;
    logic vf_s;
    logic at_tgt_s;

    assign {run_s, accel_s, decel_s, vf_s, at_tgt_s} = pins_sync;

    ////////////////////////////////////////////////////////////////////////////
    // settings registers

    logic [15:0] uv_level_reg;
    logic [15:0] ov_level_reg;
    logic        ov_method_reg;
    logic [7:0]  acc_level_reg;
    logic [7:0]  run_level_reg;
    logic [2:0]  ramp_sel_reg;
    logic        high_class_reg;
    logic        auto_rst_reg;

    logic        wr_uv;
    logic        wr_ov;
    logic        wr_meth;
    logic        wr_acc;
    logic        wr_run;
    logic        wr_sel;
    logic        wr_ctl;
    logic        flt_reset;
    logic        new_high;
    logic [15:0] uv_min;
    logic [15:0] uv_max;
    logic [15:0] ov_max;
    logic        uv_ok;
    logic        ov_ok;
    logic        cur_ok;

    assign wr_uv     = REG_WR_IN && (REG_ADDR_IN == `BVCG_OFF_UV_LEVEL);
    assign wr_ov     = REG_WR_IN && (REG_ADDR_IN == `BVCG_OFF_OV_LEVEL);
    assign wr_meth   = REG_WR_IN && (REG_ADDR_IN == `BVCG_OFF_OV_METHOD);
    assign wr_acc    = REG_WR_IN && (REG_ADDR_IN == `BVCG_OFF_ACC_LEVEL);
    assign wr_run    = REG_WR_IN && (REG_ADDR_IN == `BVCG_OFF_RUN_LEVEL);
    assign wr_sel    = REG_WR_IN && (REG_ADDR_IN == `BVCG_OFF_RAMP_SEL);
    assign wr_ctl    = REG_WR_IN && (REG_ADDR_IN == `BVCG_OFF_CONTROL);
    assign flt_reset = wr_ctl && REG_WDATA_IN[`BVCG_CTL_FLT_RESET];
    assign new_high  = REG_WDATA_IN[`BVCG_CTL_HIGH_CLASS];
    // out-of-range writes are ignored
    assign uv_min = high_class_reg ? `BVCG_UV_MIN_HI : `BVCG_UV_MIN_LO; // [R1]
    assign uv_max = high_class_reg ? `BVCG_UV_MAX_HI : `BVCG_UV_MAX_LO; // [R1]
    assign ov_max = high_class_reg ? `BVCG_OV_MAX_HI : `BVCG_OV_MAX_LO; // [R7]
    assign uv_ok  = (REG_WDATA_IN >= uv_min) && (REG_WDATA_IN <= uv_max);
    assign ov_ok  = (REG_WDATA_IN <= ov_max);
    assign cur_ok = (REG_WDATA_IN <= 16'(`BVCG_CUR_MAX)); // [R13] [R16]

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            uv_level_reg  <= `BVCG_UV_DEF_LO;
            ov_level_reg  <= `BVCG_OV_DEF_LO;
            ov_method_reg <= 1'b0;
            acc_level_reg <= `BVCG_CUR_DEF;
            run_level_reg <= `BVCG_CUR_DEF;
            ramp_sel_reg  <= 3'h0;
            high_class_reg <= 1'b0;
            auto_rst_reg  <= 1'b0;
        end else begin
            // class change reloads class defaults
            if (wr_ctl && (new_high != high_class_reg)) begin
                uv_level_reg <= new_high ? `BVCG_UV_DEF_HI : `BVCG_UV_DEF_LO; // [R1]
                ov_level_reg <= new_high ? `BVCG_OV_DEF_HI : `BVCG_OV_DEF_LO; // [R7]
            end else begin
                if (wr_uv && uv_ok) uv_level_reg <= REG_WDATA_IN;
                if (wr_ov && ov_ok) ov_level_reg <= REG_WDATA_IN;
            end
            if (wr_ctl) high_class_reg <= new_high;
            if (wr_ctl) auto_rst_reg <= REG_WDATA_IN[`BVCG_CTL_AUTO_RST];
            if (wr_meth) ov_method_reg <= REG_WDATA_IN[0]; // [R9]
            if (wr_acc && cur_ok) acc_level_reg <= REG_WDATA_IN[7:0];
            if (wr_run && cur_ok) run_level_reg <= REG_WDATA_IN[7:0];
            if (wr_sel && (REG_WDATA_IN <= 16'(`BVCG_RAMP_SEL_MAX))) begin
                ramp_sel_reg <= REG_WDATA_IN[2:0]; // [R18]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-period sampling and comparisons

    logic [15:0] volt_reg;
    logic [7:0]  curr_reg;
    logic [15:0] hyst;
    logic [16:0] uv_clear_lvl;
    logic        uv_now;
    logic        uv_recovered;
    logic        ov_en;
    logic        ov_now;
    logic        acc_over;
    logic        run_over;
    bvcg_ramp_type ramp_now;

    assign hyst         = high_class_reg ? `BVCG_HYST_HI : `BVCG_HYST_LO;
    assign uv_clear_lvl = {1'b0, uv_level_reg} + {1'b0, hyst};
    assign uv_now       = (volt_reg < uv_level_reg); // [R2]
    assign uv_recovered = ({1'b0, volt_reg} > uv_clear_lvl); // [R6]
    assign ov_en        = (ov_level_reg != 16'h0000); // [R8] [R12]
    assign ov_now       = ov_en && (volt_reg > ov_level_reg);
    assign acc_over     = vf_s && (curr_reg > acc_level_reg); // [R14]
    assign run_over     = vf_s && (curr_reg > run_level_reg); // [R14]
    assign ramp_now     = accel_s ? BVCG_RAMP_ACCEL :
                          (decel_s ? BVCG_RAMP_DECEL : BVCG_RAMP_IDLE);

    // samples taken on the strobe; decisions land one period later
    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            volt_reg <= 16'hffff;
            curr_reg <= 8'h00;
        end else if (tick) begin
            volt_reg <= BUS_VOLT_IN; // [R20]
            curr_reg <= OUT_CURR_IN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // protection state machine

    bvcg_state_type state_reg;
    bvcg_state_type state_next;
    logic [7:0]     code_reg;
    logic [7:0]     code_next;
    logic           log_reg;
    logic           log_next;
    logic [7:0]     uv_code;

    assign uv_code = (ramp_now == BVCG_RAMP_ACCEL) ? `BVCG_FC_UV_ACCEL :
                     ((ramp_now == BVCG_RAMP_DECEL) ? `BVCG_FC_UV_DECEL :
                      `BVCG_FC_UV_CONST); // [R3] [R19]

    always_comb begin
        state_next = state_reg;
        code_next  = code_reg;
        log_next   = 1'b0;
        unique case (state_reg)
            BVCG_ST_STOP: begin
                if (tick && uv_now) begin
                    state_next = BVCG_ST_STOP_UV; // [R5]
                end else if (run_s) begin
                    state_next = BVCG_ST_RUN;
                end
            end
            BVCG_ST_RUN: begin
                if (tick && uv_now) begin
                    state_next = BVCG_ST_FAULT; // [R2]
                    code_next  = uv_code; // [R3]
                    log_next   = 1'b1;
                end else if (!run_s) begin
                    state_next = BVCG_ST_STOP;
                end
            end
            BVCG_ST_FAULT: begin
                // auto restart needs the bus back above the margin
                if (flt_reset || (auto_rst_reg && tick && uv_recovered)) begin
                    state_next = BVCG_ST_STOP; // [R4]
                    code_next  = `BVCG_FC_NONE;
                end
            end
            BVCG_ST_STOP_UV: begin
                if (tick && uv_recovered) begin
                    state_next = BVCG_ST_STOP; // [R6]
                end
            end
            default: begin
                state_next = BVCG_ST_STOP;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            state_reg <= BVCG_ST_STOP;
            code_reg  <= `BVCG_FC_NONE;
            log_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            code_reg  <= code_next;
            log_reg   <= log_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stall actions, updated once per period, cleared at once when not running

    bvcg_act_type act_reg;
    bvcg_act_type act_next;
    logic         running;

    assign running = (state_reg == BVCG_ST_RUN);

    always_comb begin
        act_next = BVCG_ACT_NONE;
        if (running && decel_s && ov_now) begin
            act_next = ov_method_reg ? BVCG_ACT_REG : BVCG_ACT_HOLD; // [R10] [R11]
        end else if (running && accel_s && acc_over) begin
            act_next = BVCG_ACT_HOLD; // [R15]
        end else if (running && !accel_s && !decel_s && run_over) begin
            act_next = BVCG_ACT_DOWN; // [R17]
        end
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            act_reg <= BVCG_ACT_NONE;
        end else if (tick) begin
            act_reg <= act_next; // [R20] [R21]
        end else if (!running) begin
            act_reg <= BVCG_ACT_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs and read port

    logic [15:0] rdata_reg;
    logic [15:0] rdata_next;
    logic [15:0] status_word;

    assign DRIVE_EN_OUT          = running; // [R2]
    assign RAMP_HOLD_OUT         = (act_reg == BVCG_ACT_HOLD);
    assign RAMP_DOWN_OUT         = (act_reg == BVCG_ACT_DOWN);
    assign DECEL_REG_OUT         = (act_reg == BVCG_ACT_REG);
    assign STALL_RAMP_SEL_OUT    = ramp_sel_reg; // [R18]
    assign UNDERVOLT_STOPPED_OUT = (state_reg == BVCG_ST_STOP_UV);
    assign FAULT_OUT             = (state_reg == BVCG_ST_FAULT);
    assign FAULT_CODE_OUT        = code_reg;
    assign FAULT_LOG_OUT         = log_reg;
    assign REG_RDATA_OUT         = rdata_reg;

    assign status_word = {8'h00, at_tgt_s, act_reg, 2'b00, state_reg[3:1]};

    always_comb begin
        unique case (REG_ADDR_IN)
            `BVCG_OFF_UV_LEVEL:  rdata_next = uv_level_reg;
            `BVCG_OFF_OV_LEVEL:  rdata_next = ov_level_reg;
            `BVCG_OFF_OV_METHOD: rdata_next = {15'h0000, ov_method_reg};
            `BVCG_OFF_ACC_LEVEL: rdata_next = {8'h00, acc_level_reg};
            `BVCG_OFF_RUN_LEVEL: rdata_next = {8'h00, run_level_reg};
            `BVCG_OFF_RAMP_SEL:  rdata_next = {13'h0000, ramp_sel_reg};
            `BVCG_OFF_CONTROL:   rdata_next = {14'h0000, auto_rst_reg, high_class_reg};
            `BVCG_OFF_STATUS:    rdata_next = status_word;
            `BVCG_OFF_FAULT:     rdata_next = {8'h00, code_reg};
            `BVCG_OFF_VOLT_MON:  rdata_next = volt_reg;
            `BVCG_OFF_CURR_MON:  rdata_next = {8'h00, curr_reg};
            default:             rdata_next = 16'h0000;
        endcase
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            rdata_reg <= 16'h0000;
        end else begin
            rdata_reg <= REG_RD_IN ? rdata_next : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    property p_uv_trip;
        @(posedge CLK_IN) disable iff (!ARST_N_IN)
        (running && tick && uv_now) |=> (!DRIVE_EN_OUT && FAULT_OUT);
    endproperty
    a_uv_trip: assert property (p_uv_trip) else $error("no trip on undervoltage"); // [R2]

    property p_uv_code;
        @(posedge CLK_IN) disable iff (!ARST_N_IN)
        (running && tick && uv_now && accel_s) |=> (FAULT_CODE_OUT == 8'h0b);
    endproperty
    a_uv_code: assert property (p_uv_code) else $error("wrong accel fault code"); // [R19]

    property p_fault_latch;
        @(posedge CLK_IN) disable iff (!ARST_N_IN)
        (FAULT_OUT && !auto_rst_reg && !flt_reset) |=> FAULT_OUT;
    endproperty
    a_fault_latch: assert property (p_fault_latch) else $error("fault left alone"); // [R4]

    property p_stop_uv_nolog;
        @(posedge CLK_IN) disable iff (!ARST_N_IN)
        UNDERVOLT_STOPPED_OUT |-> (!FAULT_LOG_OUT && !DRIVE_EN_OUT);
    endproperty
    a_stop_uv_nolog: assert property (p_stop_uv_nolog) else $error("stopped uv logged"); // [R5]

    property p_stop_uv_clear;
        @(posedge CLK_IN) disable iff (!ARST_N_IN)
        (UNDERVOLT_STOPPED_OUT && tick && uv_recovered) |=> !UNDERVOLT_STOPPED_OUT;
    endproperty
    a_stop_uv_clear: assert property (p_stop_uv_clear) else $error("stopped uv stuck"); // [R6]

    property p_ov_off;
        @(posedge CLK_IN) disable iff (!ARST_N_IN)
        (ov_level_reg == 16'h0000) |-> !DECEL_REG_OUT;
    endproperty
    a_ov_off: assert property (p_ov_off) else $error("smart stall with zero level"); // [R8]

    property p_vf_only;
        @(posedge CLK_IN) disable iff (!ARST_N_IN)
        (tick && !vf_s && !(decel_s && ov_now)) |=> (!RAMP_HOLD_OUT && !RAMP_DOWN_OUT);
    endproperty
    a_vf_only: assert property (p_vf_only) else $error("current stall outside vf"); // [R14]

    property p_run_stall;
        @(posedge CLK_IN) disable iff (!ARST_N_IN)
        (tick && running && run_over && !accel_s && !decel_s) |=> RAMP_DOWN_OUT;
    endproperty
    a_run_stall: assert property (p_run_stall) else $error("no ramp down"); // [R17]

    property p_act_stable;
        @(posedge CLK_IN) disable iff (!ARST_N_IN)
        (!$past(tick) && running && $past(running)) |-> $stable(act_reg);
    endproperty
    a_act_stable: assert property (p_act_stable) else $error("action moved mid period"); // [R20]

    c_trip:     cover property (@(posedge CLK_IN) disable iff (!ARST_N_IN) FAULT_LOG_OUT);
    c_stop_uv:  cover property (@(posedge CLK_IN) disable iff (!ARST_N_IN) UNDERVOLT_STOPPED_OUT);
    c_ov_hold:  cover property (@(posedge CLK_IN) disable iff (!ARST_N_IN) RAMP_HOLD_OUT && decel_s);
    c_run_down: cover property (@(posedge CLK_IN) disable iff (!ARST_N_IN) RAMP_DOWN_OUT);

endmodule // bvcg_guard

// ==== bvcg_ramp_model.sv ====
`timescale 1ns/1ps

// ramp generator stand-in: reports ramp phase of the commanded profile
module bvcg_ramp_model
    import bvcg_pkg::*;
(
    // clock
    input  wire logic          clk_in,
    // profile and guard request
    input  wire logic          run_in,
    input  wire bvcg_ramp_type mode_in,
    input  wire logic          down_in,
    // ramp status
    output logic               accel_out,
    output logic               decel_out,
    output logic               at_target_out
);
    always_ff @(posedge clk_in) begin
        accel_out     <= run_in && (mode_in == BVCG_RAMP_ACCEL);
        decel_out     <= run_in && (mode_in == BVCG_RAMP_DECEL);
        at_target_out <= run_in && (mode_in == BVCG_RAMP_IDLE) && !down_in;
    end
endmodule // bvcg_ramp_model

// ==== tb_bus_voltage_current_stall_guard.sv ====
`timescale 1ns/1ps
`include "bvcg_defs.svh"

module tb_bus_voltage_current_stall_guard;
    import bvcg_pkg::*;
    logic          clk    = 1'b0;
    logic          arst_n = 1'b0;
    logic [3:0]    addr   = 4'h0;
    logic [15:0]   wdata  = 16'h0000;
    logic          wr     = 1'b0;
    logic          rd     = 1'b0;
    logic [15:0]   volt   = 16'd3000;
    logic [7:0]    curr   = 8'h00;
    logic          run    = 1'b0;
    logic          vf     = 1'b1;
    bvcg_ramp_type mode   = BVCG_RAMP_IDLE;
    logic [15:0]   rdata;
    logic          accel, decel, at_tgt, drive_en, hold, down, dreg, uv_stop, fault, flog;
    logic [2:0]    sel;
    logic [7:0]    fcode;
    int            failures = 0;
    int            samples_checked = 0;
    int            logs = 0;

    bvcg_guard DUT (.CLK_IN(clk), .ARST_N_IN(arst_n), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
        .BUS_VOLT_IN(volt), .OUT_CURR_IN(curr), .RUN_CMD_IN(run), .RAMP_ACCEL_IN(accel),
        .RAMP_DECEL_IN(decel), .VF_MODE_IN(vf), .AT_TARGET_IN(at_tgt),
        .DRIVE_EN_OUT(drive_en), .RAMP_HOLD_OUT(hold), .RAMP_DOWN_OUT(down),
        .DECEL_REG_OUT(dreg), .STALL_RAMP_SEL_OUT(sel), .UNDERVOLT_STOPPED_OUT(uv_stop),
        .FAULT_OUT(fault), .FAULT_CODE_OUT(fcode), .FAULT_LOG_OUT(flog));
    bvcg_ramp_model ramp (.clk_in(clk), .run_in(run), .mode_in(mode), .down_in(down),
        .accel_out(accel), .decel_out(decel), .at_target_out(at_tgt));

    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (flog === 1'b1) logs++;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask
    // two and a half sampling periods, covering the sync delay
    task automatic settle;
        repeat (2500) @(posedge clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd_chk(`BVCG_OFF_UV_LEVEL, `BVCG_UV_DEF_LO);
        rd_chk(`BVCG_OFF_OV_LEVEL, `BVCG_OV_DEF_LO);
        rd_chk(`BVCG_OFF_ACC_LEVEL, 16'd180);
        rd_chk(`BVCG_OFF_RUN_LEVEL, 16'd180);
        rd_chk(`BVCG_OFF_RAMP_SEL, 16'd0);
        wr_reg(`BVCG_OFF_UV_LEVEL, 16'd2300);
        rd_chk(`BVCG_OFF_UV_LEVEL, `BVCG_UV_DEF_LO);
        wr_reg(`BVCG_OFF_UV_LEVEL, `BVCG_UV_MIN_LO);
        rd_chk(`BVCG_OFF_UV_LEVEL, `BVCG_UV_MIN_LO);
        wr_reg(`BVCG_OFF_OV_LEVEL, 16'd4501);
        rd_chk(`BVCG_OFF_OV_LEVEL, `BVCG_OV_DEF_LO);
        wr_reg(`BVCG_OFF_ACC_LEVEL, 16'd201);
        rd_chk(`BVCG_OFF_ACC_LEVEL, 16'd180);
        wr_reg(`BVCG_OFF_RUN_LEVEL, 16'd200);
        rd_chk(`BVCG_OFF_RUN_LEVEL, 16'd200);
        wr_reg(`BVCG_OFF_RUN_LEVEL, 16'd180);
        wr_reg(`BVCG_OFF_RAMP_SEL, 16'd6);
        rd_chk(`BVCG_OFF_RAMP_SEL, 16'd0);
        wr_reg(`BVCG_OFF_RAMP_SEL, 16'd5);
        rd_chk(`BVCG_OFF_RAMP_SEL, 16'd5);
        chk(16'(sel), 16'd5);
        rd_chk(4'hf, 16'h0000);
        wr_reg(`BVCG_OFF_CONTROL, 16'h0001);
        rd_chk(`BVCG_OFF_UV_LEVEL, `BVCG_UV_DEF_HI);
        rd_chk(`BVCG_OFF_OV_LEVEL, `BVCG_OV_DEF_HI);
        wr_reg(`BVCG_OFF_CONTROL, 16'h0000);
        rd_chk(`BVCG_OFF_UV_LEVEL, `BVCG_UV_DEF_LO);
        $display("test regs done");
    endtask
    task automatic t_stall;
        wr_reg(`BVCG_OFF_ACC_LEVEL, 16'd150);
        run  <= 1'b1;
        mode <= BVCG_RAMP_ACCEL;
        curr <= 8'd160;
        settle();
        chk(16'(hold), 16'd1);
        vf <= 1'b0;
        settle();
        chk(16'(hold), 16'd0);
        vf   <= 1'b1;
        curr <= 8'd100;
        settle();
        chk(16'(hold), 16'd0);
        mode <= BVCG_RAMP_IDLE;
        curr <= 8'd190;
        settle();
        chk(16'(down), 16'd1);
        curr <= 8'd100;
        settle();
        chk(16'(down), 16'd0);
        $display("test current stall done");
    endtask
    task automatic t_ov;
        curr <= 8'd50;
        mode <= BVCG_RAMP_DECEL;
        volt <= 16'd3900;
        settle();
        chk(16'(hold), 16'd1);
        wr_reg(`BVCG_OFF_OV_METHOD, 16'd1);
        settle();
        chk(16'(dreg), 16'd1);
        volt <= 16'd3000;
        settle();
        chk(16'(dreg), 16'd0);
        wr_reg(`BVCG_OFF_OV_LEVEL, 16'd0);
        volt <= 16'd3900;
        settle();
        chk(16'({dreg, hold}), 16'd0);
        volt <= 16'd3000;
        $display("test overvoltage done");
    endtask
    task automatic t_uv;
        bvcg_ramp_type m [3] = '{BVCG_RAMP_ACCEL, BVCG_RAMP_DECEL, BVCG_RAMP_IDLE};
        logic [7:0]    c [3] = '{`BVCG_FC_UV_ACCEL, `BVCG_FC_UV_DECEL, `BVCG_FC_UV_CONST};
        for (int i = 0; i < 3; i++) begin
            mode <= m[i];
            settle();
            volt <= 16'd1700;
            settle();
            chk(16'({fault, drive_en}), 16'd2);
            chk(16'(fcode), 16'(c[i]));
            wr_reg(`BVCG_OFF_UV_LEVEL, 16'd1600);
            settle();
            chk(16'(fault), 16'd1);
            // let a healthy sample land before the reset
            volt <= 16'd3000;
            settle();
            chk(16'(fault), 16'd1);
            wr_reg(`BVCG_OFF_UV_LEVEL, `BVCG_UV_DEF_LO);
            wr_reg(`BVCG_OFF_CONTROL, 16'h0004);
            settle();
            chk(16'(fault), 16'd0);
        end
        wr_reg(`BVCG_OFF_CONTROL, 16'h0002);
        volt <= 16'd1700;
        settle();
        chk(16'(fault), 16'd1);
        volt <= 16'd3000;
        settle();
        chk(16'({fault, drive_en}), 16'd1);
        wr_reg(`BVCG_OFF_CONTROL, 16'h0000);
        chk(16'(logs), 16'd4);
        $display("test running undervoltage done");
    endtask
    task automatic t_stop;
        run <= 1'b0;
        settle();
        volt <= 16'd1700;
        settle();
        chk(16'({uv_stop, fault, drive_en}), 16'd4);
        volt <= 16'd2050;
        settle();
        chk(16'(uv_stop), 16'd1);
        volt <= 16'd2150;
        settle();
        chk(16'(uv_stop), 16'd0);
        chk(16'(logs), 16'd4);
        $display("test stopped undervoltage done");
    endtask
    task automatic stop_test;
        $display("checks=%0d mismatches=%0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        t_regs();
        t_stall();
        t_ov();
        t_uv();
        t_stop();
        stop_test();
    end
    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        stop_test();
    end
endmodule // tb_bus_voltage_current_stall_guard
